// *** common/eeprom_pkg.sv ***
// constants, states and byte roles shared by the two-wire eeprom slave
// assumes a single 250 MHz core clock that samples the serial bus pins
package eeprom_pkg;

   // array and page geometry
   localparam int MEM_WORDS_DFLT  = 2048;
   localparam int PAGE_BYTES      = 16;
   localparam int FIFO_DEPTH_DFLT = 32;
   localparam int BYTE_W          = 8;

   // timing: internal write cycle bound and core clock period
   localparam int WRITE_TIME_MS     = 3;
   localparam int NS_PER_MS         = 1000000;
   localparam int CLK_PERIOD_NS     = 4;
   localparam int WRITE_CYCLES_DFLT = WRITE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

   // input glitch filter length in core cycles
   localparam int FILTER_LEN = 3;

   // device type code in the top nibble of the device address byte
   localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // reset levels of the filtered inputs: bus idles high, straps low
   localparam logic [1:0] BUS_RST_VAL   = 2'h3;
   localparam logic [3:0] STRAP_RST_VAL = 4'h0;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_RX_BYTE = 5'h02,
      ST_RX_ACK  = 5'h04,
      ST_TX_BYTE = 5'h08,
      ST_TX_ACK  = 5'h10
   } link_state_t;

   typedef enum logic [2:0] {
      ROLE_DEV   = 3'h1,
      ROLE_WADDR = 3'h2,
      ROLE_DATA  = 3'h4
   } byte_role_t;

endpackage

// *** hdl/byte_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
// assumes one clock; full and empty are exact, no pass-through
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)(
   input  wire logic             core_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);

   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0]   count_reg;
   logic             push;
   logic             pop;

   assign in_ready_out  = (count_reg != (PTR_W+1)'(DEPTH));
   assign out_valid_out = (count_reg != '0);
   assign out_data_out  = store_reg[rd_ptr_reg];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   // storage has no reset; only the pointers and the count are reset
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= in_data_in;
      end
   end

   // pointers wrap explicitly so DEPTH need not be a power of two
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end

   property p_fifo_count;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (push && !pop) |=> (count_reg == $past(count_reg) + 1'b1);
   endproperty
   a_fifo_count: assert property (p_fifo_count)
      else $error("fifo count did not follow a push");

endmodule // byte_fifo

// *** hdl/line_filter.sv ***
// two-flop synchroniser followed by a run-length glitch filter per bit
// assumes raw inputs are asynchronous pins; output moves only after
// LEN equal samples
`timescale 1ns/10ps
module line_filter
   import eeprom_pkg::*;
#(
   parameter int               WIDTH   = 2,
   parameter int               LEN     = FILTER_LEN,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)(
   input  wire logic             core_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] raw_in,
   output logic      [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [LEN-1:0]   hist_reg [WIDTH];
   logic             level_reg [WIDTH];

   // synchroniser; meta_reg is read only by sync_reg
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
      end
   end

   // spikes shorter than LEN cycles never reach the level
   for (genvar j = 0; j < WIDTH; j++) begin : g_bit
      always_ff @(posedge core_clk_in) begin
         if (!rst_n_in) begin
            hist_reg[j]  <= {LEN{RST_VAL[j]}};
            level_reg[j] <= RST_VAL[j];
         end else begin
            hist_reg[j] <= {hist_reg[j][LEN-2:0], sync_reg[j]};
            if (&hist_reg[j]) begin
               level_reg[j] <= 1'b1;
            end else if (~|hist_reg[j]) begin
               level_reg[j] <= 1'b0;
            end
         end
      end
      assign level_out[j] = level_reg[j];

      property p_filter_stable;
         @(posedge core_clk_in) disable iff (!rst_n_in)
         (level_reg[j] != $past(level_reg[j])) |->
            ($past(&hist_reg[j]) || $past(~|hist_reg[j]));
      endproperty
      a_filter_stable: assert property (p_filter_stable)
         else $error("filtered level moved without a stable run");
   end

endmodule // line_filter

// *** hdl/two_wire_eeprom_slave.sv ***
// two-wire serial eeprom slave: bus protocol engine, flip-flop array,
// write fifo and timed internal write cycle
// assumes scl/sda/straps are asynchronous pins and sda is open drain
`timescale 1ns/10ps
module two_wire_eeprom_slave
   import eeprom_pkg::*;
#(
   parameter int MEM_WORDS    = MEM_WORDS_DFLT,
   parameter int WRITE_CYCLES = WRITE_CYCLES_DFLT,
   parameter int FIFO_DEPTH   = FIFO_DEPTH_DFLT
)(
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic wp_in,
   input  wire logic hw_addr_select_bit2_in,
   input  wire logic hw_addr_select_bit1_in,
   input  wire logic hw_addr_select_bit0_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   output logic      write_busy_out
);

   localparam int AW    = $clog2(MEM_WORDS);
   localparam int PB    = AW - BYTE_W;
   localparam int OFF_W = $clog2(PAGE_BYTES);
   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

   logic [1:0]        bus_f;
   logic [3:0]        strap_f;
   logic              scl_f;
   logic              sda_f;
   logic              wp_f;
   logic [2:0]        sel_f;
   logic              scl_q_reg;
   logic              sda_q_reg;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_ev;
   logic              stop_ev;
   link_state_t       state_reg;
   byte_role_t        role_reg;
   logic [3:0]        bit_cnt_reg;
   logic [7:0]        shift_reg;
   logic [2:0]        dev_hi_reg;
   logic [AW-1:0]     cur_addr_reg;
   logic [AW-1:0]     wr_base_reg;
   logic [OFF_W-1:0]  drain_off_reg;
   logic              wr_pend_reg;
   logic              busy_reg;
   logic [CNT_W-1:0]  busy_cnt_reg;
   logic              sda_oe_reg;
   logic              sda_out_reg;
   logic [7:0]        mem [MEM_WORDS];
   logic [7:0]        tx_load;
   logic              byte_end;
   logic              ack_ok;
   logic              fifo_in_valid;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [7:0]        fifo_out_data;
   logic              mem_we;

   // device byte match; select bits that carry page bits are not compared
   function automatic logic dev_match(input logic [7:0] b, input logic [2:0] sel);
      logic ok;
      ok = (b[7:4] == DEV_TYPE_CODE);
      for (int i = 0; i < 3; i++) begin
         if (i >= PB) begin
            ok = ok & (b[i+1] == sel[i]);
         end
      end
      return ok;
   endfunction

   // bus pins idle high; straps reset low as if pulled down
   line_filter #(.WIDTH(2), .LEN(FILTER_LEN), .RST_VAL(BUS_RST_VAL)) u_bus_filter (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .raw_in      ({scl_in, sda_in}),
      .level_out   (bus_f)
   );
   line_filter #(.WIDTH(4), .LEN(FILTER_LEN), .RST_VAL(STRAP_RST_VAL)) u_strap_filter (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .raw_in      ({wp_in, hw_addr_select_bit2_in, hw_addr_select_bit1_in,
                     hw_addr_select_bit0_in}),
      .level_out   (strap_f)
   );

   assign scl_f = bus_f[1];
   assign sda_f = bus_f[0];
   assign wp_f  = strap_f[3];
   assign sel_f = strap_f[2:0];

   // edge and condition detection on the deglitched lines
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl_f;
         sda_q_reg <= sda_f;
      end
   end
   assign scl_rise = scl_f & ~scl_q_reg;
   assign scl_fall = ~scl_f & scl_q_reg;
   assign start_ev = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
   assign stop_ev  = scl_f & scl_q_reg & ~sda_q_reg & sda_f;

   // ack decision at the falling edge that closes the eighth bit
   assign byte_end = scl_fall & (state_reg == ST_RX_BYTE) & (bit_cnt_reg == BITS_PER_BYTE);
   always_comb begin
      unique case (role_reg)
         ROLE_DEV:   ack_ok = dev_match(shift_reg, sel_f) & ~busy_reg;
         ROLE_WADDR: ack_ok = 1'b1;
         ROLE_DATA:  ack_ok = fifo_in_ready; // back-pressure shows as a nack
         default:    ack_ok = 1'b0;
      endcase
   end
   assign fifo_in_valid = byte_end & (role_reg == ROLE_DATA) & ~busy_reg;
   assign tx_load       = mem[cur_addr_reg];

   // protocol state, bit counter and shifter
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         state_reg   <= ST_IDLE;
         role_reg    <= ROLE_DEV;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
      end else if (start_ev) begin
         state_reg   <= ST_RX_BYTE;
         role_reg    <= ROLE_DEV;
         bit_cnt_reg <= 4'h0;
      end else if (stop_ev) begin
         state_reg <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
            end
            ST_RX_BYTE: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_f};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (byte_end) begin
                  state_reg <= ack_ok ? ST_RX_ACK : ST_IDLE;
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (role_reg == ROLE_DEV && shift_reg[0]) begin
                     state_reg <= ST_TX_BYTE;
                     shift_reg <= tx_load;
                  end else begin
                     state_reg <= ST_RX_BYTE;
                     role_reg  <= (role_reg == ROLE_DEV) ? ROLE_WADDR : ROLE_DATA;
                  end
               end
            end
            ST_TX_BYTE: begin
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_reg == BITS_PER_BYTE) begin
                     state_reg <= ST_TX_ACK;
                  end else begin
                     shift_reg <= {shift_reg[6:0], 1'b0};
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise && sda_f) begin
                  state_reg <= ST_IDLE;
               end else if (scl_fall) begin
                  state_reg   <= ST_TX_BYTE;
                  bit_cnt_reg <= 4'h0;
                  shift_reg   <= tx_load;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // address counter: page roll-over on writes, full wrap on reads
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         dev_hi_reg   <= 3'h0;
         cur_addr_reg <= '0;
         wr_base_reg  <= '0;
      end else if (byte_end && ack_ok && !start_ev && !stop_ev) begin
         if (role_reg == ROLE_DEV && !shift_reg[0]) begin
            for (int i = 0; i < 3; i++) begin
               dev_hi_reg[i] <= (i < PB) ? shift_reg[i+1] : 1'b0;
            end
         end else if (role_reg == ROLE_WADDR) begin
            cur_addr_reg <= AW'({dev_hi_reg, shift_reg});
            wr_base_reg  <= AW'({dev_hi_reg, shift_reg});
         end else if (role_reg == ROLE_DATA) begin
            cur_addr_reg[OFF_W-1:0] <= cur_addr_reg[OFF_W-1:0] + 1'b1;
         end
      end else if (state_reg == ST_TX_ACK && scl_rise && !sda_f) begin
         cur_addr_reg <= cur_addr_reg + 1'b1;
      end
   end

   // open-drain driver: enable high pulls sda low, updated on scl falls
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sda_oe_reg  <= 1'b0;
         sda_out_reg <= 1'b0;
      end else begin
         sda_out_reg <= 1'b0;
         if (start_ev || stop_ev) begin
            sda_oe_reg <= 1'b0;
         end else if (scl_fall) begin
            unique case (state_reg)
               ST_RX_BYTE: sda_oe_reg <= (bit_cnt_reg == BITS_PER_BYTE) & ack_ok;
               ST_RX_ACK:  sda_oe_reg <= (role_reg == ROLE_DEV && shift_reg[0]) ? ~tx_load[7]
                                                                                 : 1'b0;
               ST_TX_BYTE: sda_oe_reg <= (bit_cnt_reg == BITS_PER_BYTE) ? 1'b0 : ~shift_reg[6];
               ST_TX_ACK:  sda_oe_reg <= ~tx_load[7];
               default:    sda_oe_reg <= 1'b0;
            endcase
         end
      end
   end
   assign sda_out    = sda_out_reg;
   assign sda_oe_out = sda_oe_reg;

   // received data waits here until the frame ends
   byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
      .core_clk_in   (core_clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (fifo_in_valid),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (shift_reg),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (busy_reg),
      .out_data_out  (fifo_out_data)
   );

   // write cycle: launched by the stop (or restart) closing a write frame;
   // fixed length keeps the busy window independent of the byte count
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         wr_pend_reg   <= 1'b0;
         busy_reg      <= 1'b0;
         busy_cnt_reg  <= '0;
         drain_off_reg <= '0;
      end else begin
         if (fifo_in_valid && fifo_in_ready) begin
            wr_pend_reg <= 1'b1;
         end else if (busy_reg) begin
            wr_pend_reg <= 1'b0;
         end
         if (!busy_reg && wr_pend_reg && (stop_ev || start_ev)) begin
            busy_reg      <= 1'b1;
            busy_cnt_reg  <= '0;
            drain_off_reg <= wr_base_reg[OFF_W-1:0];
         end else if (busy_reg) begin
            busy_cnt_reg <= busy_cnt_reg + 1'b1;
            if (busy_cnt_reg == CNT_W'(WRITE_CYCLES - 1)) begin
               busy_reg <= 1'b0;
            end
         end
         if (busy_reg && fifo_out_valid) begin
            drain_off_reg <= drain_off_reg + 1'b1;
         end
      end
   end
   assign write_busy_out = busy_reg;

   // array write; protect blocks the store but the fifo still drains
   assign mem_we = busy_reg & fifo_out_valid & ~wp_f;
   always_ff @(posedge core_clk_in) begin
      if (mem_we) begin
         mem[{wr_base_reg[AW-1:OFF_W], drain_off_reg}] <= fifo_out_data;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_open_drain;
      sda_out_reg == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("sda data bit driven high");

   property p_oe_on_fall;
      (sda_oe_reg != $past(sda_oe_reg)) |-> $past(scl_fall || start_ev || stop_ev);
   endproperty
   a_oe_on_fall: assert property (p_oe_on_fall)
      else $error("sda changed away from a falling scl");

   property p_capture_rise;
      (state_reg == ST_RX_BYTE && scl_rise && !start_ev && !stop_ev) |=>
         (shift_reg[0] == $past(sda_f)) && (bit_cnt_reg == $past(bit_cnt_reg) + 4'h1);
   endproperty
   a_capture_rise: assert property (p_capture_rise)
      else $error("bit not captured on rising scl");

   property p_ack_ninth;
      (state_reg == ST_RX_ACK && $past(state_reg) != ST_RX_ACK) |->
         ($past(bit_cnt_reg) == BITS_PER_BYTE) && sda_oe_reg;
   endproperty
   a_ack_ninth: assert property (p_ack_ninth)
      else $error("ack not given after eight bits");

   property p_busy_nack;
      (byte_end && role_reg == ROLE_DEV && busy_reg && !start_ev && !stop_ev) |=>
         !sda_oe_reg && state_reg == ST_IDLE;
   endproperty
   a_busy_nack: assert property (p_busy_nack)
      else $error("command acked during write cycle");

   property p_busy_bound;
      busy_reg |-> (busy_cnt_reg < CNT_W'(WRITE_CYCLES));
   endproperty
   a_busy_bound: assert property (p_busy_bound)
      else $error("write cycle overran its bound");

   property p_wp_block;
      wp_f |-> !mem_we;
   endproperty
   a_wp_block: assert property (p_wp_block)
      else $error("array written while protected");

   property p_master_nack;
      (state_reg == ST_TX_ACK && scl_rise && sda_f && !start_ev && !stop_ev) |=>
         state_reg == ST_IDLE ##1 !sda_oe_reg;
   endproperty
   a_master_nack: assert property (p_master_nack)
      else $error("sda not released after master nack");

   property p_seq_incr;
      (state_reg == ST_TX_ACK && scl_rise && !sda_f && !start_ev && !stop_ev) |=>
         cur_addr_reg == $past(cur_addr_reg) + 1'b1;
   endproperty
   a_seq_incr: assert property (p_seq_incr)
      else $error("read address did not advance");

   property p_start_restart;
      start_ev |=> state_reg == ST_RX_BYTE && bit_cnt_reg == 4'h0 && !sda_oe_reg;
   endproperty
   a_start_restart: assert property (p_start_restart)
      else $error("start did not restart the receiver");

   c_read_byte:  cover property (state_reg == ST_TX_ACK && scl_rise && !sda_f);
   c_write_cyc:  cover property ($rose(busy_reg));
   c_wp_drain:   cover property (busy_reg && fifo_out_valid && wp_f);
   c_fifo_full:  cover property (fifo_in_valid && !fifo_in_ready);

endmodule // two_wire_eeprom_slave

// *** tb/i2c_host_model.sv ***
// bus master model for the two-wire eeprom slave: start, stop, byte out, byte in
// assumes the bench resolves the open-drain data wire and feeds it back in
`timescale 1ns/10ps
module i2c_host_model (
   output logic      scl_out,
   output logic      sda_low_out,
   input  wire logic sda_in
);
   localparam realtime Q = 31.25; // quarter of a 125 ns bus clock

   // bus idles with both lines released high
   initial begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end

   // data falls while the clock is high; also serves as repeated start
   task automatic start();
      sda_low_out = 1'b0;
      #Q scl_out = 1'b1;
      #Q sda_low_out = 1'b1;
      #Q scl_out = 1'b0;
      #Q;
   endtask

   // data rises while the clock is high, then the clock stays high
   task automatic stop();
      sda_low_out = 1'b1;
      #Q scl_out = 1'b1;
      #Q sda_low_out = 1'b0;
      #(4*Q);
   endtask

   // one clock: data set in the low half, sampled mid high half
   task automatic clk_bit(input logic b, output logic s);
      sda_low_out = !b;
      #Q scl_out = 1'b1;
      #Q s = sda_in;
      #Q scl_out = 1'b0;
      #Q;
   endtask

   task automatic wr(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'b1, ack);
   endtask

   // last byte answered high so the device lets go of the wire
   task automatic rd(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
      clk_bit(last, s);
   endtask
endmodule // i2c_host_model

// *** tb/test_two_wire_eeprom_slave.sv ***
// self-checking bench for the two-wire eeprom slave with a bus master model
// assumes a short write cycle parameter and a 256 byte array
`timescale 1ns/10ps
module test_two_wire_eeprom_slave;
   import eeprom_pkg::*;
   localparam int WR = 1000; // long enough to refuse a whole device byte
   logic       core_clk_in = 1'b0;
   logic       rst_n_in    = 1'b0;
   logic       wp_in       = 1'b0;
   logic [2:0] sel         = 3'h5;
   logic       scl, sda_low, sda_o, sda_oe, busy, sda_wire, a;
   logic [7:0] got [4];
   int         n_mismatch  = 0;
   int         compares    = 0;
   int         busy_cnt    = 0;

   // open-drain wire with pull-up: low if any party pulls
   assign sda_wire = !(sda_low || sda_oe);

   two_wire_eeprom_slave #(.MEM_WORDS(256), .WRITE_CYCLES(WR), .FIFO_DEPTH(32)) DUT (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_wire),
      .wp_in(wp_in), .hw_addr_select_bit2_in(sel[2]), .hw_addr_select_bit1_in(sel[1]),
      .hw_addr_select_bit0_in(sel[0]), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .write_busy_out(busy));
   i2c_host_model host (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_wire));

   // core clock and busy cycle counter
   initial forever #2 core_clk_in = ~core_clk_in;
   // sampled away from the launching edge so the flop value is settled
   always @(negedge core_clk_in) if (busy === 1'b1) busy_cnt++;

   task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic send(logic [7:0] b, logic exp_ack);
      host.wr(b, a);
      check("ack", !exp_ack, a);
   endtask

   // waits out the internal cycle, bounded, and checks its length
   task automatic wait_write();
      for (int i = 0; i < 2*WR && busy !== 1'b0; i++) @(negedge core_clk_in);
      check("busy_cycles", WR, busy_cnt);
      busy_cnt = 0;
   endtask

   // dummy write for the address, restart, then n sequential bytes
   task automatic read_at(logic [7:0] adr, int n);
      host.start();
      send({DEV_TYPE_CODE, sel, 1'b0}, 1);
      send(adr, 1);
      host.start();
      send({DEV_TYPE_CODE, sel, 1'b1}, 1);
      for (int i = 0; i < n; i++) host.rd(i == n-1, got[i]);
      check("oe_after_nack", 0, sda_oe);
      check("sda_out", 0, sda_o);
      host.stop();
   endtask

   task automatic write_at(logic [7:0] adr, logic [7:0] d [], logic nack_last);
      busy_cnt = 0;
      host.start();
      send({DEV_TYPE_CODE, sel, 1'b0}, 1);
      send(adr, 1);
      foreach (d[i]) send(d[i], !(nack_last && i == d.size()-1));
      host.stop();
   endtask

   task automatic t_byte_write();
      write_at(8'h10, '{8'h5A}, 0);
      host.start();
      send({DEV_TYPE_CODE, sel, 1'b0}, 0);
      host.stop();
      wait_write();
      read_at(8'h10, 1);
      check("byte", 8'h5A, got[0]);
   endtask

   task automatic t_page();
      write_at(8'h2E, '{8'h11, 8'h22, 8'h33}, 0);
      wait_write();
      read_at(8'h2E, 2); // only written cells, so no unknown reaches the wire
      check("page2E", 8'h11, got[0]);
      check("page2F", 8'h22, got[1]);
      read_at(8'h20, 1);
      check("page20", 8'h33, got[0]);
   endtask

   task automatic t_protect();
      @(negedge core_clk_in) wp_in = 1'b1;
      write_at(8'h10, '{8'h77}, 0);
      wait_write();
      @(negedge core_clk_in) wp_in = 1'b0;
      read_at(8'h10, 1);
      check("protected", 8'h5A, got[0]);
   endtask

   task automatic t_select();
      host.start();
      send({DEV_TYPE_CODE, 3'h4, 1'b0}, 0);
      host.stop();
      @(negedge core_clk_in) sel = 3'h0; // pins left open read low
      repeat (10) @(negedge core_clk_in);
      host.start();
      send(8'hA0, 1);
      host.stop();
      @(negedge core_clk_in) sel = 3'h5;
      repeat (10) @(negedge core_clk_in);
   endtask

   // 33 bytes with no drain: the last finds the fifo full
   task automatic t_fifo();
      logic [7:0] d [];
      d = new[33];
      foreach (d[i]) d[i] = i[7:0];
      write_at(8'h00, d, 1);
      wait_write();
      read_at(8'h00, 1);
      check("fifo_page", 8'h10, got[0]);
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog well beyond the expected run of about 100 us
   initial begin
      #400000;
      n_mismatch++;
      finish_test();
   end

   initial begin
      repeat (3) @(negedge core_clk_in);
      rst_n_in = 1'b1;
      repeat (10) @(negedge core_clk_in);
      t_byte_write();
      t_page();
      t_protect();
      t_select();
      t_fifo();
      finish_test();
   end
endmodule // test_two_wire_eeprom_slave
